// >>> hdl/opll_ctrl_pkg.sv
package opll_ctrl_pkg;

   // Register indices; the port carries the printed address directly
   localparam logic [11:0] ADDR_SYNC_CAL = 12'h0405;
   localparam logic [11:0] ADDR_RSVD = 12'h0406;
   localparam logic [11:0] ADDR_RATIO = 12'h0407;
   localparam logic [11:0] ADDR_POWER = 12'h0408;
   localparam logic [11:0] ADDR_UPDATE = 12'h0005;
   localparam logic [11:0] ADDR_SYNC_SRC = 12'h0500;

   // Field positions
   localparam int LOCK_OVR_BIT = 3;
   localparam int CAL_RESET_BIT = 1;
   localparam int MAN_CAL_BIT = 0;
   localparam int STARTUP_BIT = 4;
   localparam int BOTH_PD_BIT = 2;
   localparam int SECOND_PD_BIT = 1;
   localparam int FIRST_PD_BIT = 0;
   localparam int SYNC_SRC_BIT = 2;

   // Reset values
   localparam logic [7:0] SYNC_CAL_RST = 8'h20;
   localparam logic [7:0] RATIO_RST = 8'h44;
   localparam logic [7:0] POWER_RST = 8'h02;
   localparam logic [7:0] SYNC_SRC_RST = 8'h02;
   localparam logic [7:0] UPDATE_CODE = 8'h01;
   localparam logic [7:0] RSVD_READ = 8'h00;

   // Ratio encodings
   localparam logic [3:0] RATIO_RESET_CODE = 4'hF;
   localparam logic [3:0] RATIO_MAX_CODE = 4'h9;
   localparam logic [3:0] RATIO_MIN_DIV = 4'h3;

   // Bus request carrier
   typedef struct packed {
      logic [11:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bus_req_s;

   // Active prescaler state for one divider
   typedef struct packed {
      logic run;
      logic in_reset;
      logic [3:0] ratio;
   } presc_s;

   typedef enum logic [1:0] {
      CAL_IDLE = 2'b00,
      CAL_BUSY = 2'b01,
      CAL_WAIT = 2'b11
   } cal_state_e;

endpackage

// >>> hdl/output_pll_divider_control.sv
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Sync held until calibrated and locked, unless override
// - Calibration starts only on rising control bit
// - Calibration bit never self-clears
// - Ratio codes 0/1 div3, up to 9 div11
// - Code 1111 holds prescaler in reset
// - Start-up mode 0 holds prescalers until feedback seen
// - Start-up mode 1 skips that hold
// - Combined powerdown bit stops both prescalers
// - Second prescaler powerdown, default powered down
// - First prescaler powerdown, default enabled
// - Direct-source armed sync pulses on update
module output_pll_divider_control
#(
   parameter int CAL_CYCLES = 16
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire opll_ctrl_pkg::bus_req_s bus,
   output logic [7:0] rdata,
   input wire logic pll_locked,
   input wire logic feedback_detected,
   output logic cal_start,
   output logic cal_reset,
   output logic cal_busy,
   output logic sync_armed,
   output logic sync_pulse,
   output logic first_run,
   output logic [3:0] first_ratio,
   output logic second_run,
   output logic [3:0] second_ratio
);
   import opll_ctrl_pkg::*;

   logic [7:0] sh_sync_cal;
   logic [7:0] sh_ratio;
   logic [7:0] sh_power;
   logic [7:0] sh_sync_src;
   logic [7:0] act_sync_cal;
   logic [7:0] act_ratio;
   logic [7:0] act_power;
   logic update;
   logic man_cal_q;
   logic cal_rst_q;
   logic calibrated;
   logic fb_seen;
   logic [7:0] cnt;
   cal_state_e cal_state;
   cal_state_e next_cal_state;
   logic next_armed;
   presc_s p1;
   presc_s p2;

   // Ratio code to division factor; 0 and 1 both mean divide-by-3
   function automatic logic [3:0] ratio_to_div(input logic [3:0] code);
      if (code <= 4'h1)
      begin
         ratio_to_div = RATIO_MIN_DIV;
      end
      else if (code <= RATIO_MAX_CODE)
      begin
         ratio_to_div = code + 4'h2;
      end
      else
      begin
         ratio_to_div = 4'h0;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Register port
   // Update strobe; any other value is ignored
   assign update = bus.wr && (bus.addr == ADDR_UPDATE) && (bus.wdata == UPDATE_CODE);

   // Shadow writes; only the sync source byte reaches active logic without an update
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         sh_sync_cal <= SYNC_CAL_RST;
         sh_ratio <= RATIO_RST;
         sh_power <= POWER_RST;
         sh_sync_src <= SYNC_SRC_RST;
      end
      else if (bus.wr)
      begin
         if (bus.addr == ADDR_SYNC_CAL)
         begin
            sh_sync_cal <= bus.wdata;
         end
         else if (bus.addr == ADDR_RATIO)
         begin
            sh_ratio <= bus.wdata;
         end
         else if (bus.addr == ADDR_POWER)
         begin
            sh_power <= bus.wdata;
         end
         else if (bus.addr == ADDR_SYNC_SRC)
         begin
            sh_sync_src <= bus.wdata;
         end
      end
   end

   // Shadow to active on update only
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         act_sync_cal <= SYNC_CAL_RST;
         act_ratio <= RATIO_RST;
         act_power <= POWER_RST;
      end
      else if (update)
      begin
         act_sync_cal <= sh_sync_cal;
         act_ratio <= sh_ratio;
         act_power <= sh_power;
      end
   end

   // Read data one cycle later; unmapped addresses return the status byte
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         rdata <= 8'h00;
      end
      else if (bus.rd)
      begin
         if (bus.addr == ADDR_SYNC_CAL)
         begin
            rdata <= sh_sync_cal;
         end
         else if (bus.addr == ADDR_RSVD)
         begin
            rdata <= RSVD_READ;
         end
         else if (bus.addr == ADDR_RATIO)
         begin
            rdata <= sh_ratio;
         end
         else if (bus.addr == ADDR_POWER)
         begin
            rdata <= {sh_power[7:5], ~p1.run, ~p2.run, sh_power[2:0]};
         end
         else if (bus.addr == ADDR_SYNC_SRC)
         begin
            rdata <= sh_sync_src;
         end
         else
         begin
            rdata <= {4'h0, fb_seen, calibrated, sync_armed, cal_busy};
         end
      end
      else
      begin
         rdata <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Calibration
   // Edge detect on the active copy, so a held 1 never restarts it
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         man_cal_q <= 1'b0;
         cal_rst_q <= 1'b0;
         cal_start <= 1'b0;
         cal_reset <= 1'b0;
      end
      else
      begin
         man_cal_q <= act_sync_cal[MAN_CAL_BIT];
         cal_rst_q <= act_sync_cal[CAL_RESET_BIT];
         cal_start <= act_sync_cal[MAN_CAL_BIT] && !man_cal_q;
         cal_reset <= act_sync_cal[CAL_RESET_BIT] && !cal_rst_q;
      end
   end

   // Calibration sequencer: busy for CAL_CYCLES, then calibrated
   always_comb
   begin
      next_cal_state = cal_state;
      case (cal_state)
         CAL_IDLE:
         begin
            if (cal_start)
            begin
               next_cal_state = CAL_BUSY;
            end
         end
         CAL_BUSY:
         begin
            if (cnt == 8'(CAL_CYCLES - 1))
            begin
               next_cal_state = CAL_WAIT;
            end
         end
         default:
         begin
            next_cal_state = CAL_IDLE;
         end
      endcase
      if (cal_reset)
      begin
         next_cal_state = CAL_IDLE;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cal_state <= CAL_IDLE;
         cnt <= 8'h00;
         cal_busy <= 1'b0;
         calibrated <= 1'b0;
      end
      else
      begin
         cal_state <= next_cal_state;
         cnt <= (next_cal_state == CAL_BUSY && cal_state == CAL_BUSY) ? cnt + 8'h01 : 8'h00;
         cal_busy <= (next_cal_state == CAL_BUSY);
         if (cal_reset || next_cal_state == CAL_BUSY)
         begin
            calibrated <= 1'b0;
         end
         else if (cal_state == CAL_WAIT)
         begin
            calibrated <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Distribution sync
   // Lock gating unless overridden
   assign next_armed = act_sync_cal[LOCK_OVR_BIT] || (calibrated && pll_locked);

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         sync_armed <= 1'b0;
         sync_pulse <= 1'b0;
      end
      else
      begin
         sync_armed <= next_armed;
         // Pulse uses the armed state before this update lands
         sync_pulse <= update && next_armed && !sh_sync_src[SYNC_SRC_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Prescalers
   // Feedback detection latch; cleared again by a combined powerdown
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         fb_seen <= 1'b0;
      end
      else if (feedback_detected)
      begin
         fb_seen <= 1'b1;
      end
      else if (act_power[BOTH_PD_BIT])
      begin
         fb_seen <= 1'b0;
      end
   end

   // Run enables combine powerdowns, start-up hold and reset code
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         p1 <= '0;
         p2 <= '0;
      end
      else
      begin
         p1.in_reset <= act_ratio[3:0] == RATIO_RESET_CODE;
         p2.in_reset <= act_ratio[7:4] == RATIO_RESET_CODE;
         p1.ratio <= ratio_to_div(act_ratio[3:0]);
         p2.ratio <= ratio_to_div(act_ratio[7:4]);
         p1.run <= !act_power[BOTH_PD_BIT] && !act_power[FIRST_PD_BIT]
            && (fb_seen || act_power[STARTUP_BIT])
            && act_ratio[3:0] != RATIO_RESET_CODE;
         p2.run <= !act_power[BOTH_PD_BIT] && !act_power[SECOND_PD_BIT]
            && (fb_seen || act_power[STARTUP_BIT])
            && act_ratio[7:4] != RATIO_RESET_CODE;
      end
   end

   // Outputs straight from flops
   assign first_run = p1.run;
   assign first_ratio = p1.ratio;
   assign second_run = p2.run;
   assign second_ratio = p2.ratio;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   property p_update_applies;
      @(posedge clk) disable iff (!rst_n)
      (bus.wr && bus.addr == ADDR_UPDATE && bus.wdata == UPDATE_CODE) |=> act_ratio == $past(sh_ratio);
   endproperty
   a_update_applies: assert property (p_update_applies) else $error("update did not apply shadow");

   property p_no_update_hold;
      @(posedge clk) disable iff (!rst_n)
      !update |=> $stable(act_power);
   endproperty
   a_no_update_hold: assert property (p_no_update_hold) else $error("active changed without update");

   property p_cal_edge;
      @(posedge clk) disable iff (!rst_n)
      cal_start |-> $past(act_sync_cal[MAN_CAL_BIT]) && !$past(man_cal_q);
   endproperty
   a_cal_edge: assert property (p_cal_edge) else $error("calibration without rising edge");

   property p_cal_no_self_clear;
      @(posedge clk) disable iff (!rst_n)
      !(bus.wr && bus.addr == ADDR_SYNC_CAL) |=> $stable(sh_sync_cal);
   endproperty
   a_cal_no_self_clear: assert property (p_cal_no_self_clear) else $error("control byte changed unwritten");

   property p_sync_gate;
      @(posedge clk) disable iff (!rst_n)
      sync_armed |-> $past(act_sync_cal[LOCK_OVR_BIT]) || $past(calibrated && pll_locked);
   endproperty
   a_sync_gate: assert property (p_sync_gate) else $error("sync armed before lock");

   property p_both_pd;
      @(posedge clk) disable iff (!rst_n)
      act_power[BOTH_PD_BIT] |=> !first_run && !second_run;
   endproperty
   a_both_pd: assert property (p_both_pd) else $error("combined powerdown ignored");

   property p_startup_hold;
      @(posedge clk) disable iff (!rst_n)
      (!act_power[STARTUP_BIT] && !fb_seen) |=> !first_run && !second_run;
   endproperty
   a_startup_hold: assert property (p_startup_hold) else $error("prescaler ran before feedback");

   property p_reset_code;
      @(posedge clk) disable iff (!rst_n)
      (act_ratio[3:0] == RATIO_RESET_CODE) |=> p1.in_reset && !first_run;
   endproperty
   a_reset_code: assert property (p_reset_code) else $error("reset code not honoured");

   property p_ratio_map;
      @(posedge clk) disable iff (!rst_n)
      (act_ratio[7:4] <= 4'h1) |=> second_ratio == 4'h3;
   endproperty
   a_ratio_map: assert property (p_ratio_map) else $error("ratio code 0 or 1 not divide-by-3");

endmodule
`default_nettype wire

// >>> testbench/output_pll_divider_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module output_pll_divider_control_tb;
   import opll_ctrl_pkg::*;

   localparam int CALN = 4;

   logic clk;
   logic rst_n;
   bus_req_s bus;
   logic [7:0] rdata;
   logic pll_locked;
   logic feedback_detected;
   logic cal_start;
   logic cal_reset;
   logic cal_busy;
   logic sync_armed;
   logic sync_pulse;
   logic first_run;
   logic [3:0] first_ratio;
   logic second_run;
   logic [3:0] second_ratio;
   int bad_count = 0;
   int n_compared = 0;
   int n_cal = 0;
   int n_sync = 0;
   int n_crst = 0;
   int base;

   ////////////////////////////////////////////////////////////////////////////
   // Short calibration keeps the run brief
   output_pll_divider_control #(.CAL_CYCLES(CALN)) output_pll_divider_control_inst
   (
      .clk(clk),
      .rst_n(rst_n),
      .bus(bus),
      .rdata(rdata),
      .pll_locked(pll_locked),
      .feedback_detected(feedback_detected),
      .cal_start(cal_start),
      .cal_reset(cal_reset),
      .cal_busy(cal_busy),
      .sync_armed(sync_armed),
      .sync_pulse(sync_pulse),
      .first_run(first_run),
      .first_ratio(first_ratio),
      .second_run(second_run),
      .second_ratio(second_ratio)
   );

   always #5 clk = ~clk;

   // Pulse counters, so checks need no exact pulse cycle
   always @(posedge clk)
   begin
      if (cal_start === 1'b1) n_cal++;
      if (sync_pulse === 1'b1) n_sync++;
      if (cal_reset === 1'b1) n_crst++;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One-cycle write strobe, released at the next edge
   task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [11:0] a, input logic [7:0] mask, input logic [7:0] exp);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      chk("rdata", rdata & mask, exp);
   endtask

   task automatic upd();
      wr_reg(ADDR_UPDATE, UPDATE_CODE);
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic print_verdict();
      if (bad_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_state();
      wait_n(2);
      chk("first_ratio", first_ratio, 8'h06);
      chk("second_ratio", second_ratio, 8'h06);
      chk("first_run", first_run, 8'h00);
      chk("second_run", second_run, 8'h00);
      rd_reg(ADDR_RATIO, 8'hFF, RATIO_RST);
      rd_reg(ADDR_RSVD, 8'hFF, 8'h00);
      rd_reg(ADDR_POWER, 8'h07, 8'h02);
   endtask

   // Start-up hold, combined and single power-down
   task automatic t_power();
      @(posedge clk);
      feedback_detected <= 1'b1;
      wait_n(4);
      chk("first_run", first_run, 8'h01);
      chk("second_run", second_run, 8'h00);
      @(posedge clk);
      feedback_detected <= 1'b0;
      wr_reg(ADDR_POWER, 8'h00);
      upd();
      wait_n(4);
      chk("second_run", second_run, 8'h01);
      wr_reg(ADDR_POWER, 8'h04);
      upd();
      wait_n(4);
      chk("first_run", first_run, 8'h00);
      chk("second_run", second_run, 8'h00);
      wr_reg(ADDR_POWER, 8'h10);
      upd();
      wait_n(4);
      chk("first_run", first_run, 8'h01);
      chk("second_run", second_run, 8'h01);
      wr_reg(ADDR_POWER, 8'h11);
      upd();
      wait_n(4);
      chk("first_run", first_run, 8'h00);
      chk("second_run", second_run, 8'h01);
      wr_reg(ADDR_POWER, 8'h00);
      upd();
      wait_n(4);
      chk("first_run", first_run, 8'h00);
      @(posedge clk);
      feedback_detected <= 1'b1;
      @(posedge clk);
      feedback_detected <= 1'b0;
      wait_n(4);
      chk("first_run", first_run, 8'h01);
      chk("second_run", second_run, 8'h01);
   endtask

   // Shadowing, refused updates, full code table, reset code
   task automatic t_ratio();
      logic [7:0] exp;
      wr_reg(ADDR_RATIO, 8'h77);
      wr_reg(12'h0123, 8'hFF);
      wr_reg(ADDR_UPDATE, 8'h02);
      wait_n(4);
      chk("first_ratio", first_ratio, 8'h06);
      rd_reg(ADDR_RATIO, 8'hFF, 8'h77);
      for (int c = 0; c < 10; c++)
      begin
         exp = (c < 2) ? 8'h03 : 8'(c + 2);
         wr_reg(ADDR_RATIO, 8'hFF);
         upd();
         wr_reg(ADDR_RATIO, {c[3:0], c[3:0]});
         upd();
         wait_n(4);
         chk("first_ratio", first_ratio, exp);
         chk("second_ratio", second_ratio, exp);
      end
      wr_reg(ADDR_RATIO, 8'hF9);
      upd();
      wait_n(4);
      chk("second_run", second_run, 8'h00);
      chk("second_ratio", second_ratio, 8'h00);
      chk("first_ratio", first_ratio, 8'h0B);
      wr_reg(ADDR_RATIO, 8'h39);
      upd();
      wait_n(4);
      chk("second_run", second_run, 8'h01);
      chk("second_ratio", second_ratio, 8'h05);
   endtask

   // Edge-started calibration, then sync arming and direct pulse
   task automatic t_cal_sync();
      base = n_cal;
      wr_reg(ADDR_SYNC_CAL, 8'h21);
      upd();
      wait_n(2);
      chk("cal_busy", cal_busy, 8'h01);
      wait_n(CALN + 4);
      chk("cal_busy", cal_busy, 8'h00);
      chk("cal_count", 8'(n_cal - base), 8'h01);
      chk("sync_armed", sync_armed, 8'h00);
      upd();
      wait_n(CALN + 4);
      chk("cal_count", 8'(n_cal - base), 8'h01);
      rd_reg(ADDR_SYNC_CAL, 8'h0F, 8'h01);
      wr_reg(ADDR_SYNC_CAL, 8'h20);
      upd();
      wait_n(CALN + 4);
      chk("cal_count", 8'(n_cal - base), 8'h01);
      wr_reg(ADDR_RATIO, 8'h88);
      wr_reg(ADDR_SYNC_CAL, 8'h21);
      upd();
      wait_n(CALN + 4);
      chk("cal_count", 8'(n_cal - base), 8'h02);
      chk("first_ratio", first_ratio, 8'h0A);
      chk("second_ratio", second_ratio, 8'h0A);
      @(posedge clk);
      pll_locked <= 1'b1;
      wait_n(4);
      chk("sync_armed", sync_armed, 8'h01);
      base = n_sync;
      upd();
      wait_n(4);
      chk("sync_count", 8'(n_sync - base), 8'h01);
      wr_reg(ADDR_SYNC_SRC, 8'h06);
      upd();
      wait_n(4);
      chk("sync_count", 8'(n_sync - base), 8'h01);
      @(posedge clk);
      pll_locked <= 1'b0;
      wr_reg(ADDR_SYNC_CAL, 8'h28);
      upd();
      wait_n(4);
      chk("sync_armed", sync_armed, 8'h01);
      base = n_crst;
      wr_reg(ADDR_SYNC_CAL, 8'h2A);
      upd();
      wait_n(4);
      chk("crst_count", 8'(n_crst - base), 8'h01);
      rd_reg(12'h0123, 8'h0F, 8'h0A);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      rst_n = 1'b0;
      bus = '0;
      pll_locked = 1'b0;
      feedback_detected = 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_reset_state();
      t_power();
      t_ratio();
      t_cal_sync();
      print_verdict();
   end

   // Whole sequence needs well under a thousand cycles
   initial
   begin
      repeat (20000) @(posedge clk);
      bad_count++;
      print_verdict();
   end
endmodule
`default_nettype wire
